//--- design/hdcd_decoder.sv
// Host direct command decoder: splits host words into address words and
// direct commands, owns the register file and steers the RF logic.
// Assumes the link logic delivers bytes on clk and frames them by a level.
//
// How it works
// - Top bit of a host word selects command or register address.
// - Address word: bit 6 read, bit 5 continuous, bits 4..0 address.
// - A command word triggers reader action instead of a register access.
// - Idle issues one dummy cycle in parallel mode, eight in SPI mode.
// - Software initialization reloads every register like power-on.
// - Initialization gives 0x01, 0x21 and 0x00 in the first registers.
// - Protocol, timer bytes 0xC1, rx wait, rx special match power-on.
// - FIFO reset empties FIFO, clears FIFO status and collision position.
// - Immediate transmission starts once the first payload byte arrives.
// - Code 0x11 appends CRC; code 0x10 sends without CRC.
// - Codes 0x13 and 0x12 start transmission on transmit timer expiry.
// - Next-slot command acts only with the vicinity protocol selected.
// - Codes 0x18 and 0x19 measure internal and external RF levels.
// - Block receiver holds the bit decoder and framer in reset.
// - Enable receiver releases the decoder reset.
// - Blocked receiver frees at transmit end, or after nonzero wait time.
// - Both measurements write 3-bit levels into the signal level register.

`timescale 1ns/100ps
`default_nettype none

module hdcd_decoder
    import hdcd_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int INIT_CYCLES = INIT_CYCLES_DEF
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       port_is_spi,
    input  wire logic       frame_active,
    input  wire logic       word_valid,
    input  wire logic [7:0] word_data,
    input  wire logic       rd_req,
    output logic      [7:0] rd_data,
    output logic            rd_valid,
    output logic            fifo_wr,
    output logic      [7:0] fifo_wr_data,
    output logic            fifo_clear,
    output logic            tx_start,
    output logic            tx_with_crc,
    input  wire logic       tx_done,
    output logic            slot_marker,
    output logic            rx_decoder_reset,
    output logic            rssi_start,
    output logic            rssi_external,
    input  wire logic       rssi_done,
    input  wire logic [5:0] rssi_levels,
    input  wire logic [7:0] irq_set,
    input  wire logic       fifo_level_valid,
    input  wire logic [7:0] fifo_level,
    input  wire logic       col_valid,
    input  wire logic [7:0] col_pos,
    output logic            dummy_clk_en,
    output logic            init_busy,
    output logic      [7:0] chip_status,
    output logic      [7:0] protocol_sel
);

    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_tick_check
        $error("TICK_CYCLES must lie between 1 and 65535");
    end
    if (INIT_CYCLES < 1 || INIT_CYCLES > 255) begin : g_init_check
        $error("INIT_CYCLES must lie between 1 and 255");
    end

    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
    localparam logic [7:0]  INIT_LAST = 8'(INIT_CYCLES - 1);

    // Value each register takes at reset and at software initialization.
    function automatic logic [7:0] init_value(input logic [4:0] a);
        logic [7:0] v;
        v = INIT_ZERO;
        if (a == ADDR_CHIP_STATUS) begin
            v = INIT_CHIP_STATUS;
        end else if (a == ADDR_PROTOCOL) begin
            v = INIT_PROTOCOL;
        end else if (a == ADDR_TX_TIMER_HI || a == ADDR_TX_TIMER_LO) begin
            v = INIT_TX_TIMER;
        end else if (a == ADDR_RX_NORESP) begin
            v = INIT_RX_NORESP;
        end else if (a == ADDR_RX_WAIT) begin
            v = INIT_RX_WAIT;
        end else if (a == ADDR_MOD_CLK) begin
            v = INIT_MOD_CLK;
        end else if (a == ADDR_RX_SPECIAL) begin
            v = INIT_RX_SPECIAL;
        end else if (a == ADDR_REGULATOR) begin
            v = INIT_REGULATOR;
        end else if (a == ADDR_COL_MASK) begin
            v = INIT_COL_MASK;
        end else if (a == ADDR_SIGNAL_LEVEL) begin
            v = INIT_SIGNAL_LEVEL;
        end
        return v;
    endfunction

    // Locations the host may write; interrupt, collision, level and FIFO status and reserved ones only read.
    function automatic logic host_writable(input logic [4:0] a);
        logic w;
        w = 1'b1;
        if (a >= ADDR_IRQ_CAUSE && a <= ADDR_SIGNAL_LEVEL && a != ADDR_COL_MASK) begin
            w = 1'b0;
        end else if (a == ADDR_RESERVED || a == ADDR_NO_REG || a >= ADDR_FIFO_STATUS) begin
            w = 1'b0;
        end
        return w;
    endfunction

    logic [1:0]  spi_sync_reg;
    logic [7:0]  regs_reg [NUM_REGS];
    hdcd_state_t state_reg;
    logic [4:0]  ptr_reg;
    logic        cont_reg;
    logic [7:0]  init_cnt_reg;
    logic [3:0]  dummy_cnt_reg;
    logic [15:0] tick_cnt_reg;
    logic        tick;
    logic        tx_armed_reg;
    logic        tx_delayed_reg;
    logic        tx_loaded_reg;
    logic [15:0] tx_timer_reg;
    logic        tx_expired_reg;
    logic        rx_block_reg;
    logic        rx_wait_run_reg;
    logic [7:0]  rx_wait_cnt_reg;

    // Decoded events of the current word.
    logic        take;
    logic        is_cmd;
    logic [4:0]  code;
    logic        host_wr;
    logic        host_rd;
    logic        soft_init;
    logic        cmd_fifo_reset;
    logic        cmd_tx;
    logic        irq_read;
    logic        tx_fire;

    // The SPI mode strap is a pin, so it passes two flip-flops first.
    always_ff @(posedge clk) begin
        if (rst) begin
            spi_sync_reg <= 2'b00;
        end else begin
            spi_sync_reg <= {spi_sync_reg[0], port_is_spi};
        end
    end

    // Words are refused while an initialization runs.
    // words ignored during initialization
    assign take    = word_valid && frame_active && state_reg != ST_INIT;
    // top bit splits command from address
    assign is_cmd  = word_data[CMD_BIT];
    assign code    = word_data[4:0];
    assign host_wr = take && state_reg == ST_WRITE;
    assign host_rd = rd_req && frame_active && state_reg == ST_READ;
    assign soft_init      = take && state_reg == ST_HEADER && is_cmd
                            && code == CMD_SOFT_INIT;
    assign cmd_fifo_reset = take && state_reg == ST_HEADER && is_cmd
                            && code == CMD_FIFO_RESET;
    assign cmd_tx         = take && state_reg == ST_HEADER && is_cmd
                            && code >= CMD_TX_NOCRC && code <= CMD_DTX_CRC;
    assign irq_read       = host_rd && ptr_reg == ADDR_IRQ_CAUSE;

    // Word sequencing within a frame.
    // read, continuous and address fields
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg    <= ST_HEADER;
            ptr_reg      <= 5'h00;
            cont_reg     <= 1'b0;
            init_cnt_reg <= 8'h00;
        end else if (state_reg == ST_INIT) begin
            if (init_cnt_reg == INIT_LAST) begin
                state_reg <= ST_HEADER;
            end
            init_cnt_reg <= init_cnt_reg + 8'h01;
        end else if (soft_init) begin
            state_reg    <= ST_INIT;
            init_cnt_reg <= 8'h00;
        end else if (!frame_active) begin
            state_reg <= ST_HEADER;
        end else begin
            case (state_reg)
                ST_HEADER: begin
                    if (take && !is_cmd) begin
                        ptr_reg   <= word_data[4:0];
                        cont_reg  <= word_data[CONT_BIT];
                        state_reg <= word_data[READ_BIT] ? ST_READ : ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (take) begin
                        // Single mode expects a fresh address word after one byte.
                        if (cont_reg) begin
                            ptr_reg <= ptr_reg + 5'h01;
                        end else begin
                            state_reg <= ST_HEADER;
                        end
                    end
                end
                ST_READ: begin
                    if (host_rd) begin
                        if (cont_reg) begin
                            ptr_reg <= ptr_reg + 5'h01;
                        end else begin
                            state_reg <= ST_HEADER;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_HEADER;
                end
            endcase
        end
    end
    assign init_busy = state_reg == ST_INIT;

    // Register file; new interrupt events win over host clears, FIFO reset wins over status updates.
    always_ff @(posedge clk) begin
        if (rst || soft_init) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_reg[i] <= init_value(5'(i));
            end
        end else begin
            if (host_wr && host_writable(ptr_reg)) begin
                regs_reg[ptr_reg] <= word_data;
            end
            // Cause bits clear on read or protocol change but new events stick.
            if (irq_read || (host_wr && ptr_reg == ADDR_PROTOCOL)) begin
                regs_reg[ADDR_IRQ_CAUSE] <= irq_set;
            end else begin
                regs_reg[ADDR_IRQ_CAUSE] <= regs_reg[ADDR_IRQ_CAUSE] | irq_set;
            end
            // FIFO reset clears status and collision
            if (cmd_fifo_reset) begin
                regs_reg[ADDR_FIFO_STATUS] <= INIT_ZERO;
                regs_reg[ADDR_COL_POS]     <= INIT_ZERO;
            end else begin
                if (fifo_level_valid) begin
                    regs_reg[ADDR_FIFO_STATUS] <= fifo_level;
                end
                if (col_valid) begin
                    regs_reg[ADDR_COL_POS] <= col_pos;
                end
            end
            // levels land in the low six bits
            if (rssi_done) begin
                regs_reg[ADDR_SIGNAL_LEVEL][RSSI_HI:0] <= rssi_levels;
            end
        end
    end
    assign chip_status  = regs_reg[ADDR_CHIP_STATUS];
    assign protocol_sel = regs_reg[ADDR_PROTOCOL];

    // Read data; unmapped locations answer zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= host_rd;
            if (host_rd) begin
                rd_data <= (ptr_reg <= ADDR_LAST_REG && ptr_reg != ADDR_NO_REG)
                           ? regs_reg[ptr_reg] : 8'h00;
            end
        end
    end

    // Bytes written at the FIFO location go straight to the FIFO.
    always_ff @(posedge clk) begin
        if (rst) begin
            fifo_wr      <= 1'b0;
            fifo_wr_data <= 8'h00;
            fifo_clear   <= 1'b0;
        end else begin
            fifo_wr    <= host_wr && ptr_reg == ADDR_FIFO_DATA;
            fifo_clear <= cmd_fifo_reset || soft_init;
            if (host_wr) begin
                fifo_wr_data <= word_data;
            end
        end
    end

    // Single pulse commands; undefined codes fall through untouched.
    // undefined codes do nothing
    always_ff @(posedge clk) begin
        if (rst) begin
            slot_marker   <= 1'b0;
            rssi_start    <= 1'b0;
            rssi_external <= 1'b0;
        end else begin
            slot_marker <= 1'b0;
            rssi_start  <= 1'b0;
            if (take && state_reg == ST_HEADER && is_cmd) begin
                if (code == CMD_NEXT_SLOT) begin
                    slot_marker <= protocol_sel[PROTO_FAMILY_HI:PROTO_FAMILY_LO]
                                   == PROTO_VICINITY;
                end
                if (code == CMD_RSSI_INT || code == CMD_RSSI_EXT) begin
                    rssi_start    <= 1'b1;
                    rssi_external <= code == CMD_RSSI_EXT;
                end
            end
        end
    end

    // Idle command: a burst of dummy cycles sized by the port mode.
    // one or eight dummy cycles
    always_ff @(posedge clk) begin
        if (rst || soft_init) begin
            dummy_cnt_reg <= 4'h0;
        end else if (take && state_reg == ST_HEADER && is_cmd && code == CMD_IDLE) begin
            dummy_cnt_reg <= spi_sync_reg[1] ? DUMMY_SPI : DUMMY_PARALLEL;
        end else if (dummy_cnt_reg != 4'h0) begin
            dummy_cnt_reg <= dummy_cnt_reg - 4'h1;
        end
    end
    assign dummy_clk_en = dummy_cnt_reg != 4'h0;

    // Timer base; a free divider keeps one enable pulse for both timers.
    always_ff @(posedge clk) begin
        if (rst || tick) begin
            tick_cnt_reg <= 16'h0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        end
    end
    assign tick = tick_cnt_reg == TICK_LAST;

    // Transmission: arm on command, load on first payload, fire at once or, for delayed codes, on timer.
    assign tx_fire = tx_armed_reg && tx_loaded_reg
                     && (!tx_delayed_reg || tx_expired_reg);
    always_ff @(posedge clk) begin
        if (rst || soft_init) begin
            tx_armed_reg   <= 1'b0;
            tx_delayed_reg <= 1'b0;
            tx_loaded_reg  <= 1'b0;
            tx_with_crc    <= 1'b0;
            tx_start       <= 1'b0;
        end else begin
            tx_start <= tx_fire;
            if (cmd_tx) begin
                tx_armed_reg   <= 1'b1;
                tx_loaded_reg  <= 1'b0;
                // CRC chosen by lowest code bit
                tx_with_crc    <= code[0];
                tx_delayed_reg <= code[1];
            end else if (tx_fire) begin
                tx_armed_reg <= 1'b0;
            end else if (fifo_wr && tx_armed_reg) begin
                tx_loaded_reg <= 1'b1;
            end
        end
    end

    // Delay counter loaded from both timer bytes at every transmit command.
    // timer expiry gates start
    always_ff @(posedge clk) begin
        if (rst || soft_init) begin
            tx_timer_reg   <= 16'h0000;
            tx_expired_reg <= 1'b0;
        end else if (cmd_tx) begin
            tx_timer_reg   <= {regs_reg[ADDR_TX_TIMER_HI], regs_reg[ADDR_TX_TIMER_LO]};
            tx_expired_reg <= 1'b0;
        end else if (tx_timer_reg == 16'h0000) begin
            tx_expired_reg <= tx_delayed_reg && tx_armed_reg;
        end else if (tick) begin
            tx_timer_reg <= tx_timer_reg - 16'h0001;
        end
    end

    // Receiver block with release by command, transmit end or wait time.
    always_ff @(posedge clk) begin
        if (rst || soft_init) begin
            rx_block_reg    <= 1'b0;
            rx_wait_run_reg <= 1'b0;
            rx_wait_cnt_reg <= 8'h00;
        end else if (take && state_reg == ST_HEADER && is_cmd && code == CMD_RX_BLOCK) begin
            rx_block_reg    <= 1'b1;
            rx_wait_run_reg <= 1'b0;
        end else if (take && state_reg == ST_HEADER && is_cmd && code == CMD_RX_ENABLE) begin
            rx_block_reg    <= 1'b0;
            rx_wait_run_reg <= 1'b0;
        end else if (tx_done && rx_block_reg) begin
            // release at end or after wait
            rx_block_reg    <= regs_reg[ADDR_RX_WAIT] != 8'h00;
            rx_wait_run_reg <= regs_reg[ADDR_RX_WAIT] != 8'h00;
            rx_wait_cnt_reg <= regs_reg[ADDR_RX_WAIT];
        end else if (rx_wait_run_reg && tick) begin
            if (rx_wait_cnt_reg == 8'h01) begin
                rx_block_reg    <= 1'b0;
                rx_wait_run_reg <= 1'b0;
            end
            rx_wait_cnt_reg <= rx_wait_cnt_reg - 8'h01;
        end
    end
    assign rx_decoder_reset = rx_block_reg;

endmodule

`default_nettype wire

//--- design/hdcd_pkg.sv
// Constants shared by the host direct command decoder: word fields, command
// codes, register offsets and the values loaded at reset or initialization.
// Assumes an 8-bit register file of 29 locations addressed by 5-bit words.
package hdcd_pkg;

    // Fields of a host word.
    localparam int CMD_BIT  = 7;
    localparam int READ_BIT = 6;
    localparam int CONT_BIT = 5;

    // Command codes carried in bits 4 to 0.
    localparam logic [4:0] CMD_IDLE       = 5'h00;
    localparam logic [4:0] CMD_SOFT_INIT  = 5'h03;
    localparam logic [4:0] CMD_FIFO_RESET = 5'h0f;
    localparam logic [4:0] CMD_TX_NOCRC   = 5'h10;
    localparam logic [4:0] CMD_TX_CRC     = 5'h11;
    localparam logic [4:0] CMD_DTX_NOCRC  = 5'h12;
    localparam logic [4:0] CMD_DTX_CRC    = 5'h13;
    localparam logic [4:0] CMD_NEXT_SLOT  = 5'h14;
    localparam logic [4:0] CMD_RX_BLOCK   = 5'h16;
    localparam logic [4:0] CMD_RX_ENABLE  = 5'h17;
    localparam logic [4:0] CMD_RSSI_INT   = 5'h18;
    localparam logic [4:0] CMD_RSSI_EXT   = 5'h19;

    // Register offsets.
    localparam logic [4:0] ADDR_CHIP_STATUS  = 5'h00;
    localparam logic [4:0] ADDR_PROTOCOL     = 5'h01;
    localparam logic [4:0] ADDR_TX_TIMER_HI  = 5'h04;
    localparam logic [4:0] ADDR_TX_TIMER_LO  = 5'h05;
    localparam logic [4:0] ADDR_RX_NORESP    = 5'h07;
    localparam logic [4:0] ADDR_RX_WAIT      = 5'h08;
    localparam logic [4:0] ADDR_MOD_CLK      = 5'h09;
    localparam logic [4:0] ADDR_RX_SPECIAL   = 5'h0a;
    localparam logic [4:0] ADDR_REGULATOR    = 5'h0b;
    localparam logic [4:0] ADDR_IRQ_CAUSE    = 5'h0c;
    localparam logic [4:0] ADDR_COL_MASK     = 5'h0d;
    localparam logic [4:0] ADDR_COL_POS      = 5'h0e;
    localparam logic [4:0] ADDR_SIGNAL_LEVEL = 5'h0f;
    localparam logic [4:0] ADDR_RESERVED     = 5'h15;
    localparam logic [4:0] ADDR_NO_REG       = 5'h17;
    localparam logic [4:0] ADDR_FIFO_STATUS  = 5'h1c;
    localparam logic [4:0] ADDR_LAST_REG     = 5'h1c;
    localparam logic [4:0] ADDR_FIFO_DATA    = 5'h1f;
    localparam int         NUM_REGS          = 29;

    // Values loaded at reset and by software initialization.
    localparam logic [7:0] INIT_CHIP_STATUS  = 8'h01;
    localparam logic [7:0] INIT_PROTOCOL     = 8'h21;
    localparam logic [7:0] INIT_TX_TIMER     = 8'hc1;
    localparam logic [7:0] INIT_RX_NORESP    = 8'h0e;
    localparam logic [7:0] INIT_RX_WAIT      = 8'h07;
    localparam logic [7:0] INIT_MOD_CLK      = 8'h91;
    localparam logic [7:0] INIT_RX_SPECIAL   = 8'h10;
    localparam logic [7:0] INIT_REGULATOR    = 8'h87;
    localparam logic [7:0] INIT_COL_MASK     = 8'h3e;
    localparam logic [7:0] INIT_SIGNAL_LEVEL = 8'h40;
    localparam logic [7:0] INIT_ZERO         = 8'h00;

    // Protocol field that marks the vicinity-card family.
    localparam int         PROTO_FAMILY_HI   = 4;
    localparam int         PROTO_FAMILY_LO   = 3;
    localparam logic [1:0] PROTO_VICINITY    = 2'b00;

    // Placement of the two 3-bit level results.
    localparam int RSSI_HI = 5;

    // Dummy cycles issued by the idle command.
    localparam logic [3:0] DUMMY_PARALLEL = 4'h1;
    localparam logic [3:0] DUMMY_SPI      = 4'h8;

    // Timing defaults, in clock cycles.
    localparam int TICK_CYCLES_DEF = 74;
    localparam int INIT_CYCLES_DEF = 16;

    typedef enum logic [1:0] {
        ST_HEADER = 2'b00,
        ST_WRITE  = 2'b01,
        ST_READ   = 2'b10,
        ST_INIT   = 2'b11
    } hdcd_state_t;

endpackage

//--- sim/hdcd_decoder_asserts.sv
// Checker for the host direct command decoder, bound to its top module.
// Assumes every header is the first byte of a frame, as the bench sends it.
`timescale 1ns/100ps
`default_nettype none
module hdcd_decoder_asserts #(
    parameter int INIT_CYCLES = 16
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       port_is_spi,
    input wire logic       frame_active,
    input wire logic       word_valid,
    input wire logic [7:0] word_data,
    input wire logic       fifo_clear,
    input wire logic       tx_with_crc,
    input wire logic       rx_decoder_reset,
    input wire logic       dummy_clk_en,
    input wire logic       init_busy,
    input wire logic [7:0] chip_status,
    input wire logic [7:0] protocol_sel
);
    logic       first_reg;
    logic [7:0] busy_reg;
    // The first byte of a frame is a header.
    always_ff @(posedge clk) begin
        if (rst || !frame_active) first_reg <= 1'b1;
        else if (word_valid) first_reg <= 1'b0;
    end
    // Counts busy cycles.
    always_ff @(posedge clk) begin
        if (rst || !init_busy) busy_reg <= 8'h00;
        else busy_reg <= busy_reg + 8'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_cmd(logic [7:0] w);
        first_reg && frame_active && word_valid && !init_busy && word_data == w;
    endsequence
    rx_block_a: assert property (s_cmd(8'h96) |=> rx_decoder_reset)
        else $error("receiver not blocked");
    rx_enable_a: assert property (s_cmd(8'h97) |=> !rx_decoder_reset)
        else $error("receiver not released");
    fifo_reset_a: assert property (s_cmd(8'h8f) |=> fifo_clear)
        else $error("fifo not cleared");
    tx_crc_a: assert property (s_cmd(8'h91) |=> tx_with_crc)
        else $error("crc not armed");
    tx_plain_a: assert property (s_cmd(8'h90) or s_cmd(8'h92) |=> !tx_with_crc)
        else $error("crc armed on plain transmit");
    idle_par_a: assert property (s_cmd(8'h80) ##0 (!port_is_spi && !$past(port_is_spi, 4))
        |=> dummy_clk_en ##1 !dummy_clk_en)
        else $error("parallel idle not one cycle");
    idle_spi_a: assert property (s_cmd(8'h80) ##0 (port_is_spi && $past(port_is_spi, 4))
        |=> dummy_clk_en [*8] ##1 !dummy_clk_en)
        else $error("spi idle not eight cycles");
    init_vals_a: assert property (s_cmd(8'h83)
        |=> init_busy && chip_status == 8'h01 && protocol_sel == 8'h21)
        else $error("initialization values wrong");
    init_len_a: assert property ($fell(init_busy) |-> busy_reg == INIT_CYCLES)
        else $error("busy window length wrong");
    busy_ignore_a: assert property (init_busy && word_valid && word_data == 8'h96
        |=> !rx_decoder_reset)
        else $error("word taken during initialization");
endmodule
bind hdcd_decoder hdcd_decoder_asserts #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.*);
`default_nettype wire

//--- sim/hdcd_decoder_bench.sv
// Self-checking bench for the host direct command decoder.
// Assumes the host model sends each header in a frame of its own.
`timescale 1ns/100ps
`default_nettype none
module hdcd_decoder_bench;
    import hdcd_pkg::*;
    logic clk = 1'b0, rst = 1'b1, port_is_spi = 1'b0, tx_done = 1'b0, rssi_done = 1'b0;
    logic frame_active, word_valid, rd_req, rd_valid, fifo_wr, fifo_clear, tx_start;
    logic tx_with_crc, slot_marker, rx_decoder_reset, rssi_start, rssi_external;
    logic dummy_clk_en, init_busy, fifo_level_valid = 1'b0, col_valid = 1'b0;
    logic [7:0] word_data, rd_data, fifo_wr_data, fifo_level = 8'h33, col_pos = 8'h44;
    logic [7:0] irq_set = 8'h00;
    logic [7:0] chip_status, protocol_sel, q, last_fifo;
    logic [5:0] rssi_levels = 6'h2d;
    int n_errors = 0, checked = 0, cyc = 0, n_tx = 0, n_slot = 0, n_dummy = 0;
    // Rows: write flag, address, write byte, expected read.
    // target detection level is never read back.
    logic [27:0] rows [13] = '{28'h0_00_00_01, 28'h0_09_00_91, 28'h0_0d_00_3e,
        28'h0_0f_00_40, 28'h0_0b_00_87, 28'h0_01_00_21, 28'h1_0e_aa_00, 28'h1_15_aa_00,
        28'h1_17_5a_00, 28'h1_02_5a_5a, 28'h1_04_00_00, 28'h1_05_10_10, 28'h1_08_00_00};
    hdcd_host host (.*);
    hdcd_decoder #(.TICK_CYCLES(2), .INIT_CYCLES(4)) dut (.*);
    always #4 clk = ~clk;
    // Pulses are tallied on the rising edge and read on the falling edge.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (tx_start) n_tx <= n_tx + 1;
        if (slot_marker) n_slot <= n_slot + 1;
        if (dummy_clk_en) n_dummy <= n_dummy + 1;
        if (fifo_wr) last_fifo <= fifo_wr_data;
    end
    // The RF side answers one cycle later; a hang is cut off after 20000 cycles.
    always @(negedge clk) begin
        tx_done = tx_start;
        rssi_done = rssi_start;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d of %0d checks", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 13; i++) begin
            if (rows[i][24]) host.wr(rows[i][20:16], rows[i][15:8]);
            host.rd(rows[i][20:16], q);
            chk("register", rows[i][7:0], q);
        end
        host.cmd(CMD_RX_BLOCK);
        chk("rx blocked", 8'h01, {7'h0, rx_decoder_reset});
        host.cmd(CMD_TX_CRC);
        host.wr(5'h1e, 8'h10);
        host.wr(ADDR_FIFO_DATA, 8'h5c);
        repeat (10) @(negedge clk);
        chk("tx count", 8'h01, 8'(n_tx));
        chk("tx crc", 8'h01, {7'h0, tx_with_crc});
        chk("payload", 8'h5c, last_fifo);
        chk("rx freed", 8'h00, {7'h0, rx_decoder_reset});
        host.cmd(CMD_RX_BLOCK);
        host.cmd(CMD_RX_ENABLE);
        chk("rx enabled", 8'h00, {7'h0, rx_decoder_reset});
        host.cmd(CMD_DTX_NOCRC);
        host.wr(ADDR_FIFO_DATA, 8'ha7);
        chk("tx held", 8'h01, 8'(n_tx));
        repeat (60) @(negedge clk);
        chk("tx delayed", 8'h02, 8'(n_tx));
        chk("no crc", 8'h00, {7'h0, tx_with_crc});
        host.cmd(CMD_NEXT_SLOT);
        host.wr(ADDR_PROTOCOL, 8'h08);
        host.cmd(CMD_NEXT_SLOT);
        chk("slots", 8'h01, 8'(n_slot));
        host.cmd(5'h05);
        host.cmd(5'h1f);
        chk("undefined", 8'h08, protocol_sel);
        host.cmd(CMD_RSSI_INT);
        chk("internal", 8'h00, {7'h0, rssi_external});
        host.cmd(CMD_RSSI_EXT);
        chk("external", 8'h01, {7'h0, rssi_external});
        host.rd(ADDR_SIGNAL_LEVEL, q);
        chk("levels", 8'h6d, q);
        fifo_level_valid = 1'b1;
        col_valid = 1'b1;
        @(negedge clk);
        fifo_level_valid = 1'b0;
        col_valid = 1'b0;
        host.rd(ADDR_FIFO_STATUS, q);
        chk("fifo loaded", 8'h33, q);
        host.cmd(CMD_FIFO_RESET);
        host.rd(ADDR_FIFO_STATUS, q);
        chk("fifo status", 8'h00, q);
        host.rd(ADDR_COL_POS, q);
        chk("collision", 8'h00, q);
        port_is_spi = 1'b1;
        host.cmd(CMD_SOFT_INIT);
        host.cmd(CMD_RX_BLOCK);
        chk("busy ignored", 8'h00, {7'h0, rx_decoder_reset});
        repeat (4) @(negedge clk);
        host.cmd(CMD_IDLE);
        host.rd(ADDR_RX_WAIT, q);
        chk("rx wait", 8'h07, q);
        host.rd(ADDR_TX_TIMER_LO, q);
        chk("timer low", 8'hc1, q);
        host.rd(5'h02, q);
        chk("b options", 8'h00, q);
        port_is_spi = 1'b0;
        repeat (6) @(negedge clk);
        host.cmd(CMD_IDLE);
        repeat (4) @(negedge clk);
        chk("dummy cycles", 8'd9, 8'(n_dummy));
        wrap_up();
    end
endmodule
`default_nettype wire

//--- sim/hdcd_host.sv
// Host model: frames, header and data bytes, reads.
// Assumes the decoder takes a byte at each rising edge with word_valid high.
`timescale 1ns/100ps
`default_nettype none
module hdcd_host (
    input  wire logic       clk,
    output logic            frame_active,
    output logic            word_valid,
    output logic      [7:0] word_data,
    output logic            rd_req,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data
);
    initial begin
        frame_active = 1'b0;
        word_valid = 1'b0;
        word_data = 8'h00;
        rd_req = 1'b0;
    end
    // An idle bus shows the inverse byte.
    task automatic put(input logic [7:0] b);
        @(negedge clk);
        frame_active = 1'b1;
        word_valid = 1'b1;
        word_data = b;
        @(negedge clk);
        word_valid = 1'b0;
        word_data = ~b;
    endtask
    task automatic close();
        @(negedge clk);
        frame_active = 1'b0;
    endtask
    task automatic cmd(input logic [4:0] c);
        put({3'b100, c});
        close();
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        put({3'b000, a});
        put(d);
        close();
    endtask
    // The byte is taken while rd_valid stands.
    task automatic rd(input logic [4:0] a, output logic [7:0] q);
        put({3'b010, a});
        rd_req = 1'b1;
        @(negedge clk);
        rd_req = 1'b0;
        q = rd_valid ? rd_data : ~rd_data;
        close();
    endtask
endmodule
`default_nettype wire
